//--- pdw_pkg.sv
package pdw_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_CLOCK_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS     = 4'h4;
	localparam logic [3:0] OFS_CONFIG     = 4'h8;
	localparam logic [3:0] OFS_WAKE_EN    = 4'hC;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_FREQ_SEL   = 0;
	localparam int BIT_PDF        = 0;
	localparam int BIT_TOF        = 1;
	localparam int BIT_ASLEEP     = 2;
	localparam int BIT_WAKE_SRC   = 4;
	localparam int BIT_WDT_OSC_EN = 0;
	localparam int BIT_WDT_RC_SEL = 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_CLOCK_CTRL = 8'h00;
	localparam logic [7:0] RST_CONFIG     = 8'h03;
	localparam logic [7:0] RST_WAKE_EN    = 8'h00;

	// ----------------------------------------
	// Timing and counts
	// ----------------------------------------
	localparam int          RESTART_CYCLES = 1024;
	localparam logic [10:0] RESTART_LAST   = 11'h3FF;
	localparam int          PIN_COUNT      = 8;
	localparam int          IRQ_COUNT      = 4;

	// ----------------------------------------
	// Wake source codes
	// ----------------------------------------
	localparam logic [2:0] SRC_NONE = 3'h0;
	localparam logic [2:0] SRC_RST  = 3'h1;
	localparam logic [2:0] SRC_PIN  = 3'h2;
	localparam logic [2:0] SRC_IRQ  = 3'h3;
	localparam logic [2:0] SRC_WDT  = 3'h4;

	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_SLEEP = 3'b010,
		ST_WAKE  = 3'b100
	} pdw_state_t;

endpackage

//--- pdw_power_down_wakeup.sv
// Functional notes
// RL1 - System clock 6 or 12 MHz by select bit
// RL2 - Power-down stops system clock, watchdog oscillator runs
// RL3 - Config option disables watchdog RC oscillator
// RL4 - Only sleep instruction enters power-down
// RL5 - Sleep stops oscillator, halts at sleep
// RL6 - Memory, registers, ports held in power-down
// RL7 - Sleep clears watchdog; RC keeps counting, clock_frequency_select stops
// RL8 - Sleep sets powerdown flag, clears timeout flag
// RL9 - Wake on reset, pin, interrupt, watchdog overflow
// RL10 - Reset wake full reset; watchdog wake watchdog reset
// RL11 - Powerdown flag cleared by power-up, clear-watchdog
// RL12 - Timeout sets flag; wake resets PC and SP only
// RL13 - Per-pin falling-edge wake enable
// RL14 - Pin wake resumes after sleep instruction
// RL15 - Disabled interrupt or full stack resumes after sleep
// RL16 - Enabled interrupt with stack room is serviced
// RL17 - Interrupt pending at sleep cannot wake
// RL18 - Wait 1024 clocks after any wake
// RL19 - Interrupt service starts at least one cycle later
// RL20 - Next instruction runs right after the delay
// RL21 - Restart counter on system clock, release at terminal
module pdw_power_down_wakeup (
	// Clock and reset
	input  wire logic                          mclk_i,
	input  wire logic                          reset_i,
	// Avalon-MM slave
	input  wire logic [3:0]                    avs_address_i,
	input  wire logic                          avs_read_i,
	input  wire logic                          avs_write_i,
	input  wire logic [31:0]                   avs_writedata_i,
	input  wire logic [3:0]                    avs_byteenable_i,
	output logic      [31:0]                   avs_readdata_o,
	output logic                               avs_waitrequest_o,
	// Core
	input  wire logic                          sleep_exec_i,
	input  wire logic                          clr_wdt_exec_i,
	input  wire logic                          stack_full_i,
	output logic                               core_halt_o,
	output logic                               resume_next_o,
	output logic                               irq_service_o,
	output logic                               pc_sp_reset_o,
	output logic                               full_reset_o,
	// Wake sources
	input  wire logic                          ext_reset_req_i,
	input  wire logic [pdw_pkg::PIN_COUNT-1:0] pin_i,
	input  wire logic [pdw_pkg::IRQ_COUNT-1:0] irq_flag_i,
	input  wire logic [pdw_pkg::IRQ_COUNT-1:0] irq_enable_i,
	input  wire logic                          wdt_overflow_i,
	// Clocking
	output logic                               clock_frequency_select_run_o,
	output logic                               clock_frequency_select_o,
	output logic                               wdt_rc_osc_en_o,
	output logic                               wdt_clear_o,
	output logic                               wdt_run_o
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [pdw_pkg::PIN_COUNT-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
	logic [pdw_pkg::PIN_COUNT-1:0] pin_s1_nxt, pin_s2_nxt, pin_s3_nxt;
	logic                          rst_s1_r, rst_s2_r;
	logic                          rst_s1_nxt, rst_s2_nxt;
	// Overflow comes from the RC oscillator side
	logic                          wdt_s1_r, wdt_s2_r;
	logic                          wdt_s1_nxt, wdt_s2_nxt;

	always_comb begin
		pin_s1_nxt = pin_i;
		pin_s2_nxt = pin_s1_r;
		pin_s3_nxt = pin_s2_r;
		rst_s1_nxt = ext_reset_req_i;
		rst_s2_nxt = rst_s1_r;
		wdt_s1_nxt = wdt_overflow_i;
		wdt_s2_nxt = wdt_s1_r;
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_s1_r <= 8'hFF;
			pin_s2_r <= 8'hFF;
			pin_s3_r <= 8'hFF;
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
			wdt_s1_r <= 1'b0;
			wdt_s2_r <= 1'b0;
		end else begin
			pin_s1_r <= pin_s1_nxt;
			pin_s2_r <= pin_s2_nxt;
			pin_s3_r <= pin_s3_nxt;
			rst_s1_r <= rst_s1_nxt;
			rst_s2_r <= rst_s2_nxt;
			wdt_s1_r <= wdt_s1_nxt;
			wdt_s2_r <= wdt_s2_nxt;
		end
	end

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	pdw_pkg::pdw_state_t           state_r, state_nxt;
	logic [7:0]                    clk_ctrl_r, clk_ctrl_nxt;
	logic [7:0]                    config_r, config_nxt;
	logic [7:0]                    wake_en_r, wake_en_nxt;
	logic                          pdf_r, pdf_nxt;
	logic                          tof_r, tof_nxt;
	logic [2:0]                    src_r, src_nxt;
	logic [pdw_pkg::IRQ_COUNT-1:0] irq_mask_r, irq_mask_nxt;
	logic [pdw_pkg::IRQ_COUNT-1:0] irq_hit_r, irq_hit_nxt;
	logic [10:0]                   cnt_r, cnt_nxt;
	logic                          svc_pend_r, svc_pend_nxt;
	logic [31:0]                   rdata_r, rdata_nxt;
	logic                          wait_r, wait_nxt;
	logic                          halt_r, halt_nxt;
	logic                          resume_r, resume_nxt;
	logic                          svc_r, svc_nxt;
	logic                          pcsp_r, pcsp_nxt;
	logic                          full_r, full_nxt;
	logic                          wclr_r, wclr_nxt;
	logic                          wrun_r, wrun_nxt;
	logic                          sysrun_r, sysrun_nxt;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction

	logic [pdw_pkg::PIN_COUNT-1:0] pin_fall;
	logic [pdw_pkg::IRQ_COUNT-1:0] irq_wake;
	logic                          acc, wr;

	// ----------------------------------------
	// Per-pin wake detect
	// ----------------------------------------
	// Synchroniser resets high, so no false edge after reset
	genvar g;
	generate
		for (g = 0; g < pdw_pkg::PIN_COUNT; g++) begin : g_pin
			assign pin_fall[g] = pin_s3_r[g] & ~pin_s2_r[g] &
				wake_en_r[g]; // [RL13]
		end
	endgenerate

	always_comb begin
		irq_wake = irq_flag_i & ~irq_mask_r; // [RL17]
		acc      = (avs_read_i | avs_write_i) & wait_r;
		// Write lands only on the acknowledge edge
		wr       = avs_write_i & ~wait_r & avs_byteenable_i[0];
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		state_nxt    = state_r;
		clk_ctrl_nxt = clk_ctrl_r;
		config_nxt   = config_r;
		wake_en_nxt  = wake_en_r;
		pdf_nxt      = pdf_r;
		tof_nxt      = tof_r;
		src_nxt      = src_r;
		irq_mask_nxt = irq_mask_r;
		irq_hit_nxt  = irq_hit_r;
		cnt_nxt      = cnt_r;
		svc_pend_nxt = 1'b0;
		rdata_nxt    = rdata_r;
		wait_nxt     = 1'b1;
		resume_nxt   = 1'b0;
		svc_nxt      = 1'b0;
		pcsp_nxt     = 1'b0;
		full_nxt     = 1'b0;
		wclr_nxt     = 1'b0;
		// Bus: one wait cycle, then acknowledge
		if (acc) begin
			wait_nxt  = 1'b0;
			rdata_nxt = 32'h0;
			if (avs_read_i) begin
				if (hit(avs_address_i, pdw_pkg::OFS_CLOCK_CTRL))
					rdata_nxt[7:0] = clk_ctrl_r;
				else if (hit(avs_address_i, pdw_pkg::OFS_STATUS))
					rdata_nxt[7:0] = {1'b0, src_r, 1'b0,
						state_r != pdw_pkg::ST_RUN, tof_r, pdf_r};
				else if (hit(avs_address_i, pdw_pkg::OFS_CONFIG))
					rdata_nxt[7:0] = config_r;
				else if (hit(avs_address_i, pdw_pkg::OFS_WAKE_EN))
					rdata_nxt[7:0] = wake_en_r;
			end
		end
		if (wr && hit(avs_address_i, pdw_pkg::OFS_CLOCK_CTRL))
			clk_ctrl_nxt = avs_writedata_i[7:0]; // [RL1]
		if (wr && hit(avs_address_i, pdw_pkg::OFS_CONFIG))
			config_nxt = avs_writedata_i[7:0]; // [RL3]
		if (wr && hit(avs_address_i, pdw_pkg::OFS_WAKE_EN))
			wake_en_nxt = avs_writedata_i[7:0]; // [RL13]
		// Flags: hardware set wins over clear
		if (clr_wdt_exec_i)
			pdf_nxt = 1'b0; // [RL11]
		if (wdt_s2_r)
			tof_nxt = 1'b1; // [RL12]
		unique case (state_r)
			pdw_pkg::ST_RUN: begin
				if (sleep_exec_i) begin // [RL4]
					state_nxt    = pdw_pkg::ST_SLEEP; // [RL5]
					pdf_nxt      = 1'b1; // [RL8] [RL11]
					// Overflow in the same cycle still sets
					tof_nxt      = wdt_s2_r; // [RL8] [RL12]
					wclr_nxt     = 1'b1; // [RL7]
					irq_mask_nxt = irq_flag_i; // [RL17]
					src_nxt      = pdw_pkg::SRC_NONE;
				end
			end
			pdw_pkg::ST_SLEEP: begin
				// Only wake sources act; core state is frozen [RL6]
				if (rst_s2_r || wdt_s2_r || |pin_fall ||
					|irq_wake) begin // [RL9]
					state_nxt   = pdw_pkg::ST_WAKE;
					cnt_nxt     = 11'h000;
					irq_hit_nxt = irq_wake;
					if (rst_s2_r)
						src_nxt = pdw_pkg::SRC_RST;
					else if (wdt_s2_r)
						src_nxt = pdw_pkg::SRC_WDT;
					else if (|pin_fall)
						src_nxt = pdw_pkg::SRC_PIN;
					else
						src_nxt = pdw_pkg::SRC_IRQ;
				end
			end
			pdw_pkg::ST_WAKE: begin
				cnt_nxt = cnt_r + 11'h001; // [RL21]
				if (cnt_r == pdw_pkg::RESTART_LAST) begin // [RL18] [RL21]
					state_nxt = pdw_pkg::ST_RUN;
					unique case (src_r)
						pdw_pkg::SRC_RST: full_nxt = 1'b1; // [RL10]
						pdw_pkg::SRC_WDT: pcsp_nxt = 1'b1; // [RL10] [RL12]
						pdw_pkg::SRC_IRQ: begin
							if (|(irq_hit_r & irq_enable_i) && !stack_full_i)
								svc_pend_nxt = 1'b1; // [RL16] [RL19]
							else
								resume_nxt = 1'b1; // [RL15]
						end
						default: resume_nxt = 1'b1; // [RL14] [RL20]
					endcase
				end
			end
			default: state_nxt = pdw_pkg::ST_RUN;
		endcase
		// Interrupt vectoring one cycle after release
		if (svc_pend_r)
			svc_nxt = 1'b1; // [RL19]
		halt_nxt   = (state_nxt != pdw_pkg::ST_RUN) || svc_pend_nxt; // [RL5]
		sysrun_nxt = state_nxt != pdw_pkg::ST_SLEEP; // [RL2]
		// RC-clocked watchdog keeps counting in sleep
		wrun_nxt   = (state_nxt != pdw_pkg::ST_SLEEP) ||
			(config_nxt[pdw_pkg::BIT_WDT_RC_SEL] &
			config_nxt[pdw_pkg::BIT_WDT_OSC_EN]); // [RL2] [RL7]
	end

	// ----------------------------------------
	// Bus registers
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			clk_ctrl_r <= pdw_pkg::RST_CLOCK_CTRL;
			config_r   <= pdw_pkg::RST_CONFIG;
			wake_en_r  <= pdw_pkg::RST_WAKE_EN;
			rdata_r    <= 32'h0;
			wait_r     <= 1'b1;
		end else begin
			clk_ctrl_r <= clk_ctrl_nxt;
			config_r   <= config_nxt;
			wake_en_r  <= wake_en_nxt;
			rdata_r    <= rdata_nxt;
			wait_r     <= wait_nxt;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			pdf_r      <= 1'b0; // [RL11]
			tof_r      <= 1'b0;
			src_r      <= pdw_pkg::SRC_NONE;
			irq_mask_r <= 4'h0;
			irq_hit_r  <= 4'h0;
		end else begin
			pdf_r      <= pdf_nxt;
			tof_r      <= tof_nxt;
			src_r      <= src_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_hit_r  <= irq_hit_nxt;
		end
	end

	// ----------------------------------------
	// Sequencer and core outputs
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r    <= pdw_pkg::ST_RUN;
			cnt_r      <= 11'h000;
			svc_pend_r <= 1'b0;
			halt_r     <= 1'b0;
			resume_r   <= 1'b0;
			svc_r      <= 1'b0;
			pcsp_r     <= 1'b0;
			full_r     <= 1'b0;
			wclr_r     <= 1'b0;
			wrun_r     <= 1'b1;
			sysrun_r   <= 1'b1;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			svc_pend_r <= svc_pend_nxt;
			halt_r     <= halt_nxt;
			resume_r   <= resume_nxt;
			svc_r      <= svc_nxt;
			pcsp_r     <= pcsp_nxt;
			full_r     <= full_nxt;
			wclr_r     <= wclr_nxt;
			wrun_r     <= wrun_nxt;
			sysrun_r   <= sysrun_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avs_readdata_o           = rdata_r;
	assign avs_waitrequest_o        = wait_r;
	assign core_halt_o              = halt_r;
	assign resume_next_o            = resume_r;
	assign irq_service_o            = svc_r;
	assign pc_sp_reset_o            = pcsp_r;
	assign full_reset_o             = full_r;
	assign clock_frequency_select_run_o             = sysrun_r;
	assign clock_frequency_select_o = clk_ctrl_r[pdw_pkg::BIT_FREQ_SEL]; // [RL1]
	assign wdt_rc_osc_en_o          = config_r[pdw_pkg::BIT_WDT_OSC_EN]; // [RL3]
	assign wdt_clear_o              = wclr_r;
	assign wdt_run_o                = wrun_r;

endmodule

//--- pdw_monitor.sv
module pdw_monitor (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Bus
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	// Core and clocking
	input wire logic sleep_exec_i,
	input wire logic core_halt_o,
	input wire logic resume_next_o,
	input wire logic irq_service_o,
	input wire logic pc_sp_reset_o,
	input wire logic full_reset_o,
	input wire logic clock_frequency_select_run_o,
	input wire logic clock_frequency_select_o,
	input wire logic wdt_clear_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [10:0] cnt_r;
	logic [10:0] cnt_nxt;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// ----
	// Restart count, only while oscillator runs
	// ----
	always_comb begin
		cnt_nxt = core_halt_o ? cnt_r + {10'h000, clock_frequency_select_run_o} : 11'h000;
	end
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= 11'h000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	AST_SLEEP_HALT: assert property (
		sleep_exec_i && !core_halt_o |=> core_halt_o && wdt_clear_o)
		else $error("no halt after sleep");
	AST_HALT_CAUSE: assert property (
		$rose(core_halt_o) |-> $past(sleep_exec_i))
		else $error("halt without sleep");
	AST_STOP_HALTED: assert property (
		!clock_frequency_select_run_o |-> core_halt_o)
		else $error("clock stopped while running");
	AST_HOLD_FREQ: assert property (
		!clock_frequency_select_run_o |=> $stable(clock_frequency_select_o))
		else $error("freq select changed in sleep");
	AST_RESUME_DELAY: assert property (
		resume_next_o |-> !core_halt_o && cnt_r >= 11'h400 && cnt_r <= 11'h402)
		else $error("resume delay wrong");
	AST_IRQ_DELAY: assert property (
		irq_service_o |-> $past(core_halt_o) && cnt_r inside {[11'h401:11'h403]})
		else $error("irq service delay wrong");
	AST_RESET_DELAY: assert property (
		pc_sp_reset_o || full_reset_o |-> cnt_r inside {[11'h400:11'h402]})
		else $error("reset wake delay wrong");
	AST_BUS_ACK: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus ack late");
endmodule

bind pdw_power_down_wakeup pdw_monitor u_pdw_monitor (.*);

//--- pdw_core_model.sv
module pdw_core_model (
	// Clock and bench request
	input  wire logic mclk_i,
	input  wire logic sleep_req_i,
	// Core handshake
	input  wire logic core_halt_i,
	output logic      sleep_exec_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy_r = 1'b0;
	initial sleep_exec_o = 1'b0;
	// One sleep fetch per request; a halted core fetches nothing
	always_ff @(posedge mclk_i) begin
		sleep_exec_o <= sleep_req_i && !busy_r && !core_halt_i;
		busy_r <= sleep_req_i;
	end
endmodule

//--- power_down_wakeup_control_tb.sv
module power_down_wakeup_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [3:0]  avs_address_i = 4'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o, sleep_exec_i, sleep_req = 1'b0;
	logic        clr_wdt_exec_i = 1'b0;
	logic        stack_full_i = 1'b0;
	logic        ext_reset_req_i = 1'b0;
	logic        wdt_overflow_i = 1'b0;
	logic [7:0]  pin_i = 8'hFF;
	logic [3:0]  irq_flag_i = 4'h0;
	logic [3:0]  irq_enable_i = 4'h0;
	logic        core_halt_o, resume_next_o, irq_service_o, pc_sp_reset_o;
	logic        full_reset_o, clock_frequency_select_run_o, clock_frequency_select_o;
	logic        wdt_rc_osc_en_o, wdt_clear_o, wdt_run_o;
	int          n_errors = 0;
	int          n_compared = 0;
	logic [31:0] q;
	always #25 mclk_i = ~mclk_i;
	pdw_power_down_wakeup u_pdw_power_down_wakeup (.*);
	pdw_core_model u_pdw_core_model (
		.mclk_i      (mclk_i),
		.sleep_req_i (sleep_req),
		.core_halt_i (core_halt_o),
		.sleep_exec_o(sleep_exec_i)
	);
	// ----
	// Shared tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (n_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		int i;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {24'h000000, d};
		i = 0;
		do begin
			@(posedge mclk_i);
			i++;
		end while (avs_waitrequest_o !== 1'b0 && i < 20);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (i >= 20) begin
			chk("bus_ack", 1'b1, 1'b0);
			end_sim();
		end
	endtask
	task automatic st(input logic [7:0] m, input logic [7:0] e);
		bus(pdw_pkg::OFS_STATUS, 1'b0, 8'h00);
		chk("status", q & {24'h000000, m}, {24'h000000, e});
	endtask
	task automatic nap();
		@(posedge mclk_i);
		sleep_req <= 1'b1;
		repeat (4) @(posedge mclk_i);
		sleep_req <= 1'b0;
		chk("halt", core_halt_o, 1'b1);
		chk("clock_frequency_select_run", clock_frequency_select_run_o, 1'b0);
	endtask
	task automatic wake(input logic [3:0] exp);
		logic [3:0] r;
		int n;
		r = 4'h0;
		n = 0;
		while (r === 4'h0 && n < 1100) begin
			@(posedge mclk_i);
			n++;
			r = {full_reset_o, pc_sp_reset_o, irq_service_o, resume_next_o};
		end
		chk("release", r, exp);
		chk("delay", n >= 1024 && n <= 1036, 1'b1);
		if (r === 4'h0) end_sim();
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		bus(pdw_pkg::OFS_CONFIG, 1'b0, 8'h00);
		chk("config", q, 32'h3);
		bus(4'h2, 1'b1, 8'hFF);
		bus(4'h2, 1'b0, 8'h00);
		chk("unmapped", q, 32'h0);
		chk("freq_rst", clock_frequency_select_o, 1'b0);
		bus(pdw_pkg::OFS_CLOCK_CTRL, 1'b1, 8'h01);
		bus(pdw_pkg::OFS_CLOCK_CTRL, 1'b0, 8'h00);
		chk("freq_sel", clock_frequency_select_o, 1'b1);
	endtask
	task automatic t_wdt();
		nap();
		chk("wdt_run", wdt_run_o, 1'b1);
		wdt_overflow_i <= 1'b1;
		@(posedge mclk_i);
		wdt_overflow_i <= 1'b0;
		wake(4'b0100);
		st(8'h77, 8'h43);
	endtask
	task automatic t_pin();
		bus(pdw_pkg::OFS_WAKE_EN, 1'b1, 8'h01);
		nap();
		st(8'h07, 8'h05);
		pin_i <= 8'hFD;
		repeat (20) @(posedge mclk_i);
		chk("pin_off", core_halt_o, 1'b1);
		pin_i <= 8'hFC;
		wake(4'b0001);
		pin_i <= 8'hFF;
		clr_wdt_exec_i <= 1'b1;
		@(posedge mclk_i);
		clr_wdt_exec_i <= 1'b0;
		st(8'h01, 8'h00);
	endtask
	task automatic t_irq();
		irq_enable_i <= 4'hF;
		irq_flag_i <= 4'h1;
		nap();
		repeat (40) @(posedge mclk_i);
		chk("irq_masked", core_halt_o, 1'b1);
		irq_flag_i <= 4'h3;
		wake(4'b0010);
		stack_full_i <= 1'b1;
		nap();
		irq_flag_i <= 4'h7;
		wake(4'b0001);
		stack_full_i <= 1'b0;
		irq_flag_i <= 4'h0;
	endtask
	task automatic t_rst();
		bus(pdw_pkg::OFS_CONFIG, 1'b1, 8'h00);
		bus(pdw_pkg::OFS_CONFIG, 1'b0, 8'h00);
		chk("rc_osc", wdt_rc_osc_en_o, 1'b0);
		nap();
		chk("wdt_stop", wdt_run_o, 1'b0);
		ext_reset_req_i <= 1'b1;
		wake(4'b1000);
		ext_reset_req_i <= 1'b0;
	endtask
	initial begin
		repeat (8) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_regs();
		t_wdt();
		t_pin();
		t_irq();
		t_rst();
		end_sim();
	end
endmodule
